//--- verilog/edm_monitor.sv
// External device monitor: actuator drive with two-contact feedback check
//
// Overview of operation
// - A low upstream request forces the drive off; high allows switching on.
// - First feedback low means switched, high means default state.
// - Second feedback low means switched, high means default state.
// - Response limit is a constant longest response time, default zero ms.
// - Both feedbacks must show default state before the drive is asserted.
// - After drive on, both feedbacks must switch within the response limit.
// - Drive high enables the actuator, low disables; result checked on feedback.
// - Enable low sends any state to idle, above every other transition.
// - On error: drive low, error flag high, diagnostic shows error state.
// - A feedback error is cleared by a rising edge of the reset input while the request is low, or by enable low.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module edm_monitor import edm_pkg::*; #(
  parameter int unsigned RESPONSE_LIMIT_MS = RESPONSE_LIMIT_MS_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic upstream_request,
  input wire logic feedback_first,
  input wire logic feedback_second,
  input wire logic auto_start_permit,
  input wire logic fault_reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  output logic ready,
  output logic actuator_drive,
  output logic error,
  output logic [15:0] diagnostic_code,
  output logic irq
);

  // Longest time rounds down, but never below one cycle
  localparam longint unsigned LIMIT_RAW = longint'(RESPONSE_LIMIT_MS) * longint'(CYCLES_PER_MS);
  localparam logic [TIMER_W-1:0] LIMIT_CYCLES =
    (LIMIT_RAW == 0) ? TIMER_W'(1) : TIMER_W'(LIMIT_RAW);

  edm_state_e state_reg;
  edm_state_e state_next;
  logic reset_prev_reg;
  logic reset_rise;
  logic ctrl_hold_off_reg;
  logic request_eff;
  localparam int unsigned FB_N = 2;
  logic [FB_N-1:0] fb_raw;
  logic [FB_N-1:0] fb_default;
  logic fb_both_default;
  logic fb_both_switched;
  logic timer_start;
  logic timer_run;
  logic timer_expired;
  logic [EVT_W-1:0] events;
  logic [EVT_W-1:0] irq_status;
  logic [EVT_W-1:0] irq_enable;
  logic irq_en_wr;
  logic irq_clr_wr;
  logic ready_next;
  logic drive_next;
  logic error_next;
  logic [15:0] diag_next;

  // Feedback polarity: high is the resting default, low is switched
  assign fb_raw = {feedback_second, feedback_first};
  for (genvar ch = 0; ch < FB_N; ch++) begin : g_fb
    assign fb_default[ch] = fb_raw[ch];
  end
  // Shorting both inputs to one contact still passes these checks
  assign fb_both_default = &fb_default;
  assign fb_both_switched = ~|fb_default;

  // Software hold acts like a low request, so it can only switch off
  assign request_eff = upstream_request && !ctrl_hold_off_reg;

  // Level-high would re-clear an error forever on a stuck reset; edge avoids it
  assign reset_rise = fault_reset && !reset_prev_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reset_prev_reg <= 1'b0;
    end else begin
      reset_prev_reg <= fault_reset;
    end
  end

  // Next-state logic; disable is checked first so it outranks every path
  always_comb begin
    state_next = state_reg;
    timer_start = 1'b0;
    if (!enable) begin
      state_next = EDM_IDLE;
    end else begin
      case (state_reg)
        EDM_IDLE: begin
          state_next = EDM_INIT;
        end
        EDM_INIT: begin
          // Without the permit, a reset edge is the start acknowledge
          if (auto_start_permit || reset_rise) begin
            state_next = EDM_OFF;
          end
        end
        EDM_OFF: begin
          if (request_eff) begin
            if (fb_both_default) begin
              state_next = EDM_ON_WAIT;
              timer_start = 1'b1;
            end else begin
              state_next = EDM_ERR_OFF;
            end
          end
        end
        EDM_ON_WAIT: begin
          if (!request_eff) begin
            state_next = EDM_OFF_WAIT;
            timer_start = 1'b1;
          end else if (fb_both_switched) begin
            state_next = EDM_ACTIVE;
          end else if (timer_expired) begin
            state_next = EDM_ERR_ON;
          end
        end
        EDM_ACTIVE: begin
          if (!request_eff) begin
            state_next = EDM_OFF_WAIT;
            timer_start = 1'b1;
          end else if (!fb_both_switched) begin
            // A contact dropping out while driven is a feedback fault
            state_next = EDM_ERR_ON;
          end
        end
        EDM_OFF_WAIT: begin
          if (fb_both_default) begin
            state_next = EDM_OFF;
          end else if (timer_expired) begin
            state_next = EDM_ERR_OFF;
          end
        end
        EDM_ERR_ON, EDM_ERR_OFF: begin
          // Leaving with the request still high would re-energise at once
          if (reset_rise && !request_eff) begin
            state_next = EDM_OFF;
          end
        end
        default: begin
          state_next = EDM_ERR_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= EDM_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign timer_run = (state_reg == EDM_ON_WAIT) || (state_reg == EDM_OFF_WAIT);

  edm_timer #(
    .WIDTH(TIMER_W),
    .LIMIT_CYCLES(LIMIT_CYCLES)
  ) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .start(timer_start),
    .run(timer_run),
    .expired(timer_expired)
  );

  // Output decode from the next state keeps outputs aligned with the state
  always_comb begin
    ready_next = 1'b1;
    drive_next = 1'b0;
    error_next = 1'b0;
    diag_next = DIAG_IDLE;
    case (state_next)
      EDM_IDLE: begin
        ready_next = 1'b0;
        diag_next = DIAG_IDLE;
      end
      EDM_INIT: begin
        diag_next = DIAG_INIT;
      end
      EDM_OFF: begin
        diag_next = DIAG_OFF;
      end
      EDM_ON_WAIT: begin
        drive_next = 1'b1;
        diag_next = DIAG_ON_WAIT;
      end
      EDM_ACTIVE: begin
        drive_next = 1'b1;
        diag_next = DIAG_ACTIVE;
      end
      EDM_OFF_WAIT: begin
        diag_next = DIAG_OFF_WAIT;
      end
      EDM_ERR_ON: begin
        error_next = 1'b1;
        diag_next = DIAG_ERR_ON;
      end
      EDM_ERR_OFF: begin
        error_next = 1'b1;
        diag_next = DIAG_ERR_OFF;
      end
      default: begin
        error_next = 1'b1;
        diag_next = DIAG_ERR_OFF;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ready <= 1'b0;
      error <= 1'b0;
      diagnostic_code <= DIAG_IDLE;
    end else begin
      ready <= ready_next;
      error <= error_next;
      diagnostic_code <= diag_next;
    end
  end

  // Drive kept in its own process so nothing else can hold it high
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      actuator_drive <= 1'b0;
    end else begin
      actuator_drive <= drive_next && request_eff;
    end
  end

  // Events are pulses on entry to the named state; off-confirmed only when EDM_OFF is entered from EDM_OFF_WAIT
  always_comb begin
    events = '0;
    events[EVT_ERROR] = (state_next == EDM_ERR_ON || state_next == EDM_ERR_OFF) &&
                        !(state_reg == EDM_ERR_ON || state_reg == EDM_ERR_OFF);
    events[EVT_ON_CONFIRMED] = (state_next == EDM_ACTIVE) && (state_reg != EDM_ACTIVE);
    events[EVT_OFF_CONFIRMED] = (state_next == EDM_OFF) && (state_reg == EDM_OFF_WAIT);
    events[EVT_DISABLED] = (state_next == EDM_IDLE) && (state_reg != EDM_IDLE);
  end

  assign irq_en_wr = reg_write && (reg_addr == OFS_IRQ_EN);
  assign irq_clr_wr = reg_write && (reg_addr == OFS_IRQ_CLR);

  edm_irq #(
    .WIDTH(EVT_W)
  ) u_irq (
    .clock(clock),
    .rst_n(rst_n),
    .events(events),
    .enable_wr(irq_en_wr),
    .clear_wr(irq_clr_wr),
    .wdata(reg_wdata[EVT_W-1:0]),
    .status(irq_status),
    .enable(irq_enable),
    .irq(irq)
  );

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_hold_off_reg <= CTRL_RESET_VALUE;
    end else if (reg_write && reg_addr == OFS_CONTROL) begin
      ctrl_hold_off_reg <= reg_wdata[CTRL_HOLD_OFF_BIT];
    end
  end

  // Read data valid only in the cycle after the strobe; zero otherwise
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (!reg_read) begin
      reg_rdata <= '0;
    end else if (reg_addr == OFS_STATUS) begin
      reg_rdata <= DATA_W'(irq_status);
    end else if (reg_addr == OFS_IRQ_EN) begin
      reg_rdata <= DATA_W'(irq_enable);
    end else if (reg_addr == OFS_STATE) begin
      reg_rdata <= '0;
      reg_rdata[15:0] <= diagnostic_code;
      reg_rdata[ST_READY_BIT] <= ready;
      reg_rdata[ST_DRIVE_BIT] <= actuator_drive;
      reg_rdata[ST_ERROR_BIT] <= error;
      reg_rdata[ST_FB1_BIT] <= feedback_first;
      reg_rdata[ST_FB2_BIT] <= feedback_second;
    end else if (reg_addr == OFS_CONTROL) begin
      reg_rdata <= '0;
      reg_rdata[CTRL_HOLD_OFF_BIT] <= ctrl_hold_off_reg;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

//--- verilog/edm_pkg.sv
// Shared constants, register map and state encoding of the external device monitor
package edm_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;
  localparam int unsigned RESPONSE_LIMIT_MS_DEFAULT = 0;
  localparam int unsigned TIMER_W = 32;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_EN = 8'h04;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0c;
  localparam logic [7:0] OFS_CONTROL = 8'h10;

  localparam int unsigned EVT_W = 4;
  localparam int unsigned EVT_ERROR = 0;
  localparam int unsigned EVT_ON_CONFIRMED = 1;
  localparam int unsigned EVT_OFF_CONFIRMED = 2;
  localparam int unsigned EVT_DISABLED = 3;

  localparam int unsigned ST_READY_BIT = 16;
  localparam int unsigned ST_DRIVE_BIT = 17;
  localparam int unsigned ST_ERROR_BIT = 18;
  localparam int unsigned ST_FB1_BIT = 19;
  localparam int unsigned ST_FB2_BIT = 20;
  localparam int unsigned CTRL_HOLD_OFF_BIT = 0;
  localparam logic CTRL_RESET_VALUE = 1'h0;
  localparam logic [EVT_W-1:0] IRQ_EN_RESET_VALUE = 4'h0;

  localparam logic [15:0] DIAG_IDLE = 16'h0000;
  localparam logic [15:0] DIAG_INIT = 16'h8001;
  localparam logic [15:0] DIAG_OFF = 16'h8010;
  localparam logic [15:0] DIAG_ON_WAIT = 16'h8012;
  localparam logic [15:0] DIAG_ACTIVE = 16'h8000;
  localparam logic [15:0] DIAG_OFF_WAIT = 16'h8011;
  localparam logic [15:0] DIAG_ERR_ON = 16'hc091;
  localparam logic [15:0] DIAG_ERR_OFF = 16'hc090;

  typedef enum logic [2:0] {
    EDM_IDLE = 3'h0,
    EDM_INIT = 3'h1,
    EDM_OFF = 3'h3,
    EDM_ON_WAIT = 3'h2,
    EDM_ACTIVE = 3'h6,
    EDM_OFF_WAIT = 3'h7,
    EDM_ERR_ON = 3'h5,
    EDM_ERR_OFF = 3'h4
  } edm_state_e;

endpackage

//--- verilog/edm_timer.sv
// Response-time down counter for the device monitor
`timescale 1ns/1ps
module edm_timer import edm_pkg::*; #(
  parameter int unsigned WIDTH = TIMER_W,
  parameter logic [WIDTH-1:0] LIMIT_CYCLES = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic run,
  output logic expired
);

  logic [WIDTH-1:0] count_reg;
  logic running_reg;

  // Loads on start; a limit of one cycle means expiry on the next edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_reg <= '0;
      running_reg <= 1'b0;
    end else if (start) begin
      count_reg <= LIMIT_CYCLES - 1'b1;
      running_reg <= 1'b1;
    end else if (!run) begin
      running_reg <= 1'b0;
    end else if (running_reg && count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign expired = running_reg && run && (count_reg == '0);

endmodule

//--- verilog/edm_irq.sv
// Sticky event status, enable mask and interrupt line
`timescale 1ns/1ps
module edm_irq import edm_pkg::*; #(
  parameter int unsigned WIDTH = EVT_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] events,
  input wire logic enable_wr,
  input wire logic clear_wr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] status,
  output logic [WIDTH-1:0] enable,
  output logic irq
);

  logic [WIDTH-1:0] status_next;

  // Set beats clear so an event in the clearing cycle survives
  always_comb begin
    status_next = status;
    if (clear_wr) begin
      status_next = status_next & ~wdata;
    end
    status_next = status_next | events;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status <= status_next;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      enable <= IRQ_EN_RESET_VALUE;
    end else if (enable_wr) begin
      enable <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_next & (enable_wr ? wdata : enable));
    end
  end

endmodule

//--- verif/edm_monitor_properties.sv
// Port-level assertions for the device monitor
`timescale 1ns/1ps
module edm_monitor_properties import edm_pkg::*; #(
  parameter int unsigned RESPONSE_LIMIT_MS = RESPONSE_LIMIT_MS_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic upstream_request,
  input wire logic feedback_first,
  input wire logic feedback_second,
  input wire logic fault_reset,
  input wire logic ready,
  input wire logic actuator_drive,
  input wire logic error,
  input wire logic [15:0] diagnostic_code
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Timeout check only holds for the one-cycle limit
  sequence s_on_late;
    RESPONSE_LIMIT_MS == 0 && diagnostic_code == DIAG_ON_WAIT && enable && upstream_request
      && (feedback_first || feedback_second);
  endsequence
  sequence s_err_on;
    error && diagnostic_code == DIAG_ERR_ON && !actuator_drive;
  endsequence
  property p_req_off;
    !upstream_request |=> !actuator_drive;
  endproperty
  a_req_off: assert property (p_req_off) else $error("drive high after low request");
  property p_disable;
    !enable |=> diagnostic_code == DIAG_IDLE && !ready && !actuator_drive && !error;
  endproperty
  a_disable: assert property (p_disable) else $error("no idle after enable low");
  property p_idle_out;
    diagnostic_code == DIAG_IDLE |-> !ready && !actuator_drive && !error;
  endproperty
  a_idle_out: assert property (p_idle_out) else $error("idle outputs not low");
  property p_err_out;
    error |-> !actuator_drive && (diagnostic_code == DIAG_ERR_ON || diagnostic_code == DIAG_ERR_OFF);
  endproperty
  a_err_out: assert property (p_err_out) else $error("error state outputs wrong");
  property p_start_check;
    $rose(actuator_drive) |-> $past(feedback_first) && $past(feedback_second) && $past(upstream_request);
  endproperty
  a_start_check: assert property (p_start_check) else $error("drive rose without default feedback");
  property p_on_timeout;
    s_on_late |=> s_err_on;
  endproperty
  a_on_timeout: assert property (p_on_timeout) else $error("late switch not flagged");
  property p_on_confirm;
    diagnostic_code == DIAG_ON_WAIT && enable && upstream_request && !feedback_first && !feedback_second
      |=> diagnostic_code == DIAG_ACTIVE && actuator_drive;
  endproperty
  a_on_confirm: assert property (p_on_confirm) else $error("switched feedback not confirmed");
  property p_contact_lost;
    diagnostic_code == DIAG_ACTIVE && enable && upstream_request && (feedback_first || feedback_second)
      |=> s_err_on;
  endproperty
  a_contact_lost: assert property (p_contact_lost) else $error("lost contact not flagged");
  property p_err_clear;
    $fell(error) |-> !$past(enable)
      || ($past(fault_reset) && !$past(fault_reset, 2) && !$past(upstream_request));
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error cleared without reset");
  property p_off_timeout;
    RESPONSE_LIMIT_MS == 0 && diagnostic_code == DIAG_OFF_WAIT && enable && !(feedback_first && feedback_second)
      |=> error && diagnostic_code == DIAG_ERR_OFF && !actuator_drive;
  endproperty
  a_off_timeout: assert property (p_off_timeout) else $error("late release not flagged");
endmodule

bind edm_monitor edm_monitor_properties #(.RESPONSE_LIMIT_MS(RESPONSE_LIMIT_MS)) i_edm_monitor_properties (
  .clock(clock),
  .rst_n(rst_n),
  .enable(enable),
  .upstream_request(upstream_request),
  .feedback_first(feedback_first),
  .feedback_second(feedback_second),
  .fault_reset(fault_reset),
  .ready(ready),
  .actuator_drive(actuator_drive),
  .error(error),
  .diagnostic_code(diagnostic_code)
);

//--- verif/edm_actuator_model.sv
// Behavioural actuator with two feedback contacts
`timescale 1ns/1ps
module edm_actuator_model (
  input wire logic clock,
  input wire logic drive,
  input wire logic slow,
  input wire logic weld,
  input wire logic drop,
  output logic feedback_first,
  output logic feedback_second
);
  logic [2:0] lag_reg = 3'h0;
  logic moved;
  always_ff @(posedge clock) begin
    lag_reg <= {lag_reg[1:0], drive};
  end
  // Prompt mode answers in the same cycle, as a zero limit demands
  // One common contact feeds both inputs unless a fault is injected
  assign moved = slow ? lag_reg[2] : drive;
  assign feedback_first = drop ? 1'b1 : ~moved;
  assign feedback_second = weld ? 1'b0 : ~moved;
endmodule

//--- verif/tb_external_device_monitor.sv
// Directed bench for the external device monitor
`timescale 1ns/1ps
module tb_external_device_monitor import edm_pkg::*;;
  logic clock;
  logic rst_n = 1'b0;
  logic enable = 1'b0;
  logic upstream_request = 1'b0;
  logic auto_start_permit = 1'b0;
  logic fault_reset = 1'b0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h0;
  logic slow = 1'b0;
  logic weld = 1'b0;
  logic drop = 1'b0;
  logic fb1, fb2, ready, actuator_drive, error, irq;
  logic [DATA_W-1:0] reg_rdata;
  logic [15:0] diagnostic_code;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;

  edm_monitor #(.RESPONSE_LIMIT_MS(0)) i_edm_monitor (.clock(clock), .rst_n(rst_n), .enable(enable),
    .upstream_request(upstream_request), .feedback_first(fb1), .feedback_second(fb2),
    .auto_start_permit(auto_start_permit), .fault_reset(fault_reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .ready(ready), .actuator_drive(actuator_drive), .error(error), .diagnostic_code(diagnostic_code), .irq(irq));
  edm_actuator_model i_edm_actuator_model (.clock(clock), .drive(actuator_drive), .slow(slow), .weld(weld),
    .drop(drop), .feedback_first(fb1), .feedback_second(fb2));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Generous ceiling; the sequence needs about a hundred cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      give_verdict;
    end
  end

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(name, exp, reg_rdata);
  endtask

  task wait_diag(input logic [15:0] d);
    int i;
    i = 0;
    do begin
      @(posedge clock);
      #1;
      i++;
    end while (diagnostic_code !== d && i < 20);
    chk("diagnostic_code", 32'(d), 32'(diagnostic_code));
  endtask

  task pulse_reset;
    @(posedge clock) fault_reset <= 1'b1;
    @(posedge clock) fault_reset <= 1'b0;
  endtask

  task outs(input logic [2:0] exp);
    chk("ready drive error", 32'(exp), 32'({ready, actuator_drive, error}));
  endtask

  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    chk("idle diag", 32'(DIAG_IDLE), 32'(diagnostic_code));
    outs(3'h0);
    rd(OFS_IRQ_EN, 32'(IRQ_EN_RESET_VALUE), "irq enable reset");
    rd(OFS_CONTROL, 32'(CTRL_RESET_VALUE), "control reset");
    wr(8'h20, 32'hffffffff);
    rd(8'h20, 32'h0, "unmapped");
    @(posedge clock) enable <= 1'b1;
    wait_diag(DIAG_INIT);
    outs(3'h4);
    pulse_reset;
    wait_diag(DIAG_OFF);
    rd(OFS_STATE, 32'h0019_8010, "state off");
    @(posedge clock) upstream_request <= 1'b1;
    wait_diag(DIAG_ACTIVE);
    outs(3'h6);
    rd(OFS_STATE, 32'h0003_8000, "state active");
    wr(OFS_CONTROL, 32'h1);
    wait_diag(DIAG_OFF);
    outs(3'h4);
    @(posedge clock) upstream_request <= 1'b0;
    rd(OFS_CONTROL, 32'h1, "control");
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_STATUS, 32'h0);
    rd(OFS_STATUS, 32'h6, "status confirmed");
    chk("irq masked", 32'h0, 32'(irq));
    wr(OFS_IRQ_CLR, 32'hf);
    rd(OFS_STATUS, 32'h0, "status cleared");
    wr(OFS_IRQ_EN, 32'h1);
    @(posedge clock) begin
      slow <= 1'b1;
      upstream_request <= 1'b1;
    end
    wait_diag(DIAG_ERR_ON);
    outs(3'h5);
    chk("irq raised", 32'h1, 32'(irq));
    pulse_reset;
    repeat (2) @(posedge clock);
    #1;
    chk("refused clear", 32'(DIAG_ERR_ON), 32'(diagnostic_code));
    @(posedge clock) upstream_request <= 1'b0;
    pulse_reset;
    wait_diag(DIAG_OFF);
    outs(3'h4);
    @(posedge clock) slow <= 1'b0;
    wr(OFS_IRQ_CLR, 32'h1);
    #1;
    chk("irq cleared", 32'h0, 32'(irq));
    @(posedge clock) begin
      weld <= 1'b1;
      upstream_request <= 1'b1;
    end
    wait_diag(DIAG_ERR_OFF);
    outs(3'h5);
    @(posedge clock) begin
      weld <= 1'b0;
      upstream_request <= 1'b0;
    end
    pulse_reset;
    wait_diag(DIAG_OFF);
    @(posedge clock) upstream_request <= 1'b1;
    wait_diag(DIAG_ACTIVE);
    @(posedge clock) drop <= 1'b1;
    wait_diag(DIAG_ERR_ON);
    @(posedge clock) begin
      drop <= 1'b0;
      upstream_request <= 1'b0;
    end
    pulse_reset;
    wait_diag(DIAG_OFF);
    @(posedge clock) upstream_request <= 1'b1;
    wait_diag(DIAG_ACTIVE);
    @(posedge clock) begin
      weld <= 1'b1;
      upstream_request <= 1'b0;
    end
    wait_diag(DIAG_ERR_OFF);
    outs(3'h5);
    @(posedge clock) weld <= 1'b0;
    pulse_reset;
    wait_diag(DIAG_OFF);
    @(posedge clock) upstream_request <= 1'b1;
    wait_diag(DIAG_ACTIVE);
    @(posedge clock) enable <= 1'b0;
    wait_diag(DIAG_IDLE);
    outs(3'h0);
    rd(OFS_STATUS, 32'hb, "status sticky");
    chk("irq pending", 32'h1, 32'(irq));
    wr(OFS_IRQ_EN, 32'h0);
    #1;
    chk("irq masked again", 32'h0, 32'(irq));
    @(posedge clock) begin
      upstream_request <= 1'b0;
      auto_start_permit <= 1'b1;
      enable <= 1'b1;
    end
    wait_diag(DIAG_OFF);
    give_verdict;
  end
endmodule
